// >>> src/swb_cam.sv
// entry store: circular fifo with address snoop, merge and collapse
`timescale 1ns/1ps
module swb_cam #(
    parameter int DEPTH = swb_pkg::DEPTH
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    swb_cam_if.cam    cif
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = swb_pkg::CNT_W;

    typedef struct packed {
        swb_pkg::swb_entry_s [DEPTH-1:0] ent;
        logic [PW-1:0]                   head;
        logic [PW-1:0]                   tail;
        logic [CW-1:0]                   count;
    } swb_cam_s;

    swb_cam_s         st;
    swb_cam_s         next_st;
    logic [DEPTH-1:0] wrHitVec;
    logic [DEPTH-1:0] snHitVec;
    logic [PW-1:0]    wrIdx;
    logic [PW-1:0]    snIdx;
    logic             alloc;

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : gCmp
            assign wrHitVec[g] = st.ent[g].valid
                && (st.ent[g].addr == cif.wrAddr)
                && !(cif.lockHead && (st.head == PW'(g)));
            assign snHitVec[g] = st.ent[g].valid
                && (st.ent[g].addr == cif.snoopAddr);
        end
    endgenerate

    always_comb
    begin
        wrIdx = '0;
        snIdx = '0;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (wrHitVec[i])
                wrIdx = PW'(i);
            if (snHitVec[i])
                snIdx = PW'(i);
        end
    end

    assign cif.wrHit     = |wrHitVec;
    assign cif.count     = st.count;
    assign cif.headAddr  = st.ent[st.head].addr;
    assign cif.headData  = st.ent[st.head].data;
    assign cif.headBe    = st.ent[st.head].be;
    assign cif.snoopBe   = (|snHitVec) ? st.ent[snIdx].be : '0;
    assign cif.snoopData = st.ent[snIdx].data;

    always_comb
    begin
        next_st = st;
        alloc = 1'b0;
        if (cif.wrValid)
        begin
            if (|wrHitVec)
            begin
                // merge or collapse into the hit level
                for (int b = 0; b < swb_pkg::BE_W; b++)
                    if (cif.wrBe[b])
                        next_st.ent[wrIdx].data[8*b +: 8] =
                            cif.wrData[8*b +: 8];
                next_st.ent[wrIdx].be = st.ent[wrIdx].be | cif.wrBe;
            end
            else
            begin
                // new level only on a miss
                alloc = 1'b1;
                next_st.ent[st.tail].valid = 1'b1;
                next_st.ent[st.tail].addr  = cif.wrAddr;
                next_st.ent[st.tail].be    = cif.wrBe;
                next_st.ent[st.tail].data  = cif.wrData;
                next_st.tail = st.tail + PW'(1);
            end
        end
        if (cif.pop)
        begin
            next_st.ent[st.head].valid = 1'b0;
            next_st.head = st.head + PW'(1);
        end
        next_st.count = st.count + CW'(alloc) - CW'(cif.pop);
    end

    // levels of doubleword, tag and byte valids
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st <= '0;
        else
            st <= next_st;
    end
endmodule

// >>> src/swb_cam_if.sv
// carrier between controller, entry store and read merge
`timescale 1ns/1ps
interface swb_cam_if;
    logic                          wrValid;
    logic [swb_pkg::ADDR_W-1:0]    wrAddr;
    logic [swb_pkg::DATA_W-1:0]    wrData;
    logic [swb_pkg::BE_W-1:0]      wrBe;
    logic                          wrHit;
    logic                          lockHead;
    logic                          pop;
    logic [swb_pkg::CNT_W-1:0]     count;
    logic [swb_pkg::ADDR_W-1:0]    headAddr;
    logic [swb_pkg::DATA_W-1:0]    headData;
    logic [swb_pkg::BE_W-1:0]      headBe;
    logic [swb_pkg::ADDR_W-1:0]    snoopAddr;
    logic [swb_pkg::DATA_W-1:0]    snoopData;
    logic [swb_pkg::BE_W-1:0]      snoopBe;
    logic [swb_pkg::DATA_W-1:0]    memData;
    logic [swb_pkg::DATA_W-1:0]    mergedData;

    modport ctl (
        output wrValid, wrAddr, wrData, wrBe, lockHead, pop,
        output snoopAddr, memData,
        input  wrHit, count, headAddr, headData, headBe, mergedData
    );
    modport cam (
        input  wrValid, wrAddr, wrData, wrBe, lockHead, pop, snoopAddr,
        output wrHit, count, headAddr, headData, headBe,
        output snoopData, snoopBe
    );
    modport merge (
        input  snoopData, snoopBe, memData,
        output mergedData
    );
endinterface

// >>> src/swb_pkg.sv
// shared constants and types of the snooping write buffer
package swb_pkg;

    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;
    localparam int DEPTH  = 32;
    localparam int CNT_W  = 6;

    localparam logic [CNT_W-1:0] DEPTH_CNT = 6'h20;

    // threshold levels in doublewords
    localparam logic [CNT_W-1:0] THR_LVL0 = 6'h08;
    localparam logic [CNT_W-1:0] THR_LVL1 = 6'h10;
    localparam logic [CNT_W-1:0] THR_LVL2 = 6'h18;
    localparam logic [CNT_W-1:0] THR_LVL3 = 6'h1c;

    localparam int          REG_ADDR_W = 12;
    localparam logic [11:0] CTL_OFFSET = 12'h040;
    localparam logic [7:0]  CTL_RESET  = 8'h00;
    localparam int          CTL_ENABLE_BIT  = 0;
    localparam int          CTL_RDAHEAD_BIT = 1;
    localparam int          CTL_THR_LSB     = 2;
    localparam int          CTL_THR_W       = 2;
    localparam int          CTL_FLUSH_BIT   = 4;

    typedef enum logic [1:0] {
        PORT_IDLE,
        PORT_READ,
        PORT_DRAIN,
        PORT_DIRECT
    } swb_port_e;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [BE_W-1:0]   be;
        logic [DATA_W-1:0] data;
    } swb_entry_s;

endpackage

// >>> src/swb_rdmerge.sv
// read merge: buffered bytes replace bytes returned from sdram
`timescale 1ns/1ps
module swb_rdmerge (
    swb_cam_if.merge cif
);
    // valid buffered bytes win, all four replace fully
    genvar b;
    generate
        for (b = 0; b < swb_pkg::BE_W; b++)
        begin : gByte
            assign cif.mergedData[8*b +: 8] = cif.snoopBe[b]
                ? cif.snoopData[8*b +: 8]
                : cif.memData[8*b +: 8];
        end
    endgenerate
endmodule

// >>> src/swb_top.sv
// snooping posted write buffer of the sdram controller
`timescale 1ns/1ps
module swb_top #(
    parameter int DEPTH = swb_pkg::DEPTH
) (
    input  wire logic                             clk_sys,
    input  wire logic                             resetn,
    input  wire logic                             regWrEn,
    input  wire logic                             regRdEn,
    input  wire logic [swb_pkg::REG_ADDR_W-1:0]   regAddr,
    input  wire logic [7:0]                       regWrData,
    output logic      [7:0]                       regRdData,
    output logic                                  readAheadEnable,
    input  wire logic                             mstWrReq,
    input  wire logic [swb_pkg::ADDR_W-1:0]       mstWrAddr,
    input  wire logic [swb_pkg::DATA_W-1:0]       mstWrData,
    input  wire logic [swb_pkg::BE_W-1:0]         mstWrBe,
    output logic                                  mstWrReady,
    input  wire logic                             mstRdReq,
    input  wire logic [swb_pkg::ADDR_W-1:0]       mstRdAddr,
    output logic                                  mstRdAck,
    output logic      [swb_pkg::DATA_W-1:0]       mstRdData,
    output logic                                  memCmdValid,
    output logic                                  memCmdWrite,
    output logic      [swb_pkg::ADDR_W-1:0]       memCmdAddr,
    output logic      [swb_pkg::DATA_W-1:0]       memCmdData,
    output logic      [swb_pkg::BE_W-1:0]         memCmdBe,
    input  wire logic                             memCmdDone,
    input  wire logic [swb_pkg::DATA_W-1:0]       memRdData,
    output logic                                  svcReq,
    input  wire logic                             svcGrant,
    input  wire logic                             refreshReq
);
    localparam int CW = swb_pkg::CNT_W;

    typedef struct packed {
        logic                          enable;
        logic                          rdAhead;
        logic [swb_pkg::CTL_THR_W-1:0] thr;
        logic                          flush;
        logic [7:0]                    regRd;
        logic                          wrReady;
        logic                          rdAck;
        logic [swb_pkg::DATA_W-1:0]    rdData;
        swb_pkg::swb_port_e            port;
        logic                          cmdValid;
        logic                          cmdWrite;
        logic [swb_pkg::ADDR_W-1:0]    cmdAddr;
        logic [swb_pkg::DATA_W-1:0]    cmdData;
        logic [swb_pkg::BE_W-1:0]      cmdBe;
        logic                          svcReq;
        logic                          parked;
    } swb_top_s;

    swb_top_s      st;
    swb_top_s      next_st;
    logic          wrAccept;
    logic          hwFlush;
    logic          drainWanted;
    logic          startDrain;
    logic          startRead;
    logic          startDirect;
    logic          popHead;
    logic          alloc;
    logic          ctlHit;
    logic [CW-1:0] newCount;
    logic [CW-1:0] thrLevel;

    swb_cam_if cif ();

    swb_cam #(
        .DEPTH (DEPTH)
    ) uCam (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .cif     (cif)
    );

    swb_rdmerge uMerge (
        .cif (cif)
    );

    assign regRdData       = st.regRd;
    assign readAheadEnable = st.rdAhead;
    assign mstWrReady      = st.wrReady;
    assign mstRdAck        = st.rdAck;
    assign mstRdData       = st.rdData;
    assign memCmdValid     = st.cmdValid;
    assign memCmdWrite     = st.cmdWrite;
    assign memCmdAddr      = st.cmdAddr;
    assign memCmdData      = st.cmdData;
    assign memCmdBe        = st.cmdBe;
    assign svcReq          = st.svcReq;

    always_comb
    begin
        unique case (st.thr)
            2'h0: thrLevel = swb_pkg::THR_LVL0;
            2'h1: thrLevel = swb_pkg::THR_LVL1;
            2'h2: thrLevel = swb_pkg::THR_LVL2;
            2'h3: thrLevel = swb_pkg::THR_LVL3;
        endcase
    end

    // enabled writes go to the store in the accept cycle
    assign wrAccept      = mstWrReq && st.wrReady;
    assign cif.wrValid   = wrAccept && st.enable;
    assign cif.wrAddr    = mstWrAddr;
    assign cif.wrData    = mstWrData;
    assign cif.wrBe      = mstWrBe;
    // snoop the address of the command in flight
    assign cif.snoopAddr = st.cmdAddr;
    assign cif.memData   = memRdData;
    assign cif.pop       = popHead;
    // head in flight is frozen so a late merge is never lost
    assign cif.lockHead  = startDrain || (st.port == swb_pkg::PORT_DRAIN);
    assign ctlHit        = cif.wrHit;
    assign alloc         = cif.wrValid && !ctlHit;
    // occupancy once this cycle's allocate and retire land
    assign newCount      = cif.count + CW'(alloc) - CW'(popHead);

    assign hwFlush     = !st.enable && (cif.count != '0);
    // parked drain runs while the grant stands and no refresh is requested
    assign drainWanted = (st.parked && svcGrant && !refreshReq)
                      || st.flush || hwFlush;

    // one sdram command at a time, chosen in idle
    always_comb
    begin
        startDrain  = 1'b0;
        startRead   = 1'b0;
        startDirect = 1'b0;
        if (st.port == swb_pkg::PORT_IDLE)
        begin
            if (hwFlush)
                startDrain = 1'b1;
            else if (wrAccept && !st.enable)
                startDirect = 1'b1;
            // read goes ahead of flush and parked drains, but not of the disable drain
            else if (mstRdReq && !st.rdAck)
                startRead = 1'b1;
            else if (drainWanted && (cif.count != '0))
                startDrain = 1'b1;
        end
    end

    always_comb
    begin
        next_st = st;
        // read ack stands for one cycle only
        next_st.rdAck = 1'b0;
        popHead = 1'b0;

        unique case (st.port)
            swb_pkg::PORT_IDLE:
            begin
                if (startDrain)
                begin
                    next_st.cmdValid = 1'b1;
                    next_st.cmdWrite = 1'b1;
                    next_st.cmdAddr  = cif.headAddr;
                    next_st.cmdData  = cif.headData;
                    next_st.cmdBe    = cif.headBe;
                    next_st.port     = swb_pkg::PORT_DRAIN;
                end
                else if (startDirect)
                begin
                    next_st.cmdValid = 1'b1;
                    next_st.cmdWrite = 1'b1;
                    next_st.cmdAddr  = mstWrAddr;
                    next_st.cmdData  = mstWrData;
                    next_st.cmdBe    = mstWrBe;
                    next_st.port     = swb_pkg::PORT_DIRECT;
                end
                else if (startRead)
                begin
                    next_st.cmdValid = 1'b1;
                    next_st.cmdWrite = 1'b0;
                    next_st.cmdAddr  = mstRdAddr;
                    next_st.cmdBe    = '1;
                    next_st.port     = swb_pkg::PORT_READ;
                end
            end
            swb_pkg::PORT_READ:
            begin
                if (memCmdDone)
                begin
                    next_st.cmdValid = 1'b0;
                    next_st.rdAck    = 1'b1;
                    next_st.rdData   = cif.mergedData;
                    next_st.port     = swb_pkg::PORT_IDLE;
                end
            end
            swb_pkg::PORT_DRAIN:
            begin
                if (memCmdDone)
                begin
                    popHead          = 1'b1;
                    next_st.cmdValid = 1'b0;
                    next_st.port     = swb_pkg::PORT_IDLE;
                end
            end
            swb_pkg::PORT_DIRECT:
            begin
                if (memCmdDone)
                begin
                    next_st.cmdValid = 1'b0;
                    next_st.port     = swb_pkg::PORT_IDLE;
                end
            end
        endcase

        // register port
        if (regRdEn)
            next_st.regRd = (regAddr == swb_pkg::CTL_OFFSET)
                ? {3'h0, st.flush, st.thr, st.rdAhead, st.enable}
                : 8'h00;
        if (st.flush && (newCount == '0) && !cif.lockHead)
            next_st.flush = 1'b0;
        if (regWrEn && (regAddr == swb_pkg::CTL_OFFSET))
        begin
            // enable and read-ahead are separate bits
            next_st.enable  = regWrData[swb_pkg::CTL_ENABLE_BIT];
            next_st.rdAhead = regWrData[swb_pkg::CTL_RDAHEAD_BIT];
            next_st.thr     = regWrData[swb_pkg::CTL_THR_LSB +:
                                        swb_pkg::CTL_THR_W];
            // software starts a manual drain, set wins
            if (regWrData[swb_pkg::CTL_FLUSH_BIT])
                next_st.flush = 1'b1;
        end

        // park on grant, drop on read while enabled, refresh or grant loss
        if (st.svcReq && svcGrant)
            next_st.parked = 1'b1;
        if (st.parked && (!svcGrant || refreshReq
                          || (mstRdReq && st.enable)))
        begin
            next_st.parked = 1'b0;
            next_st.svcReq = 1'b0;
        end
        // empty buffer has nothing to ask service for
        if (newCount == '0)
        begin
            next_st.parked = 1'b0;
            next_st.svcReq = 1'b0;
        end
        if (alloc && (newCount > thrLevel))
            next_st.svcReq = 1'b1;

        // enabled: ready when a level is free; disabled: ready when buffer is empty and sdram port is idle
        next_st.wrReady = next_st.enable
            ? (newCount < swb_pkg::DEPTH_CNT)
            : ((newCount == '0) && (next_st.port == swb_pkg::PORT_IDLE));
    end

    // state register; reset leaves the buffer disabled
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st        <= '0;
            st.enable <= swb_pkg::CTL_RESET[swb_pkg::CTL_ENABLE_BIT];
            st.port   <= swb_pkg::PORT_IDLE;
        end
        else
            st <= next_st;
    end
endmodule

// >>> tb/swb_mem_model.sv
// sdram side and arbiter stand-in facing the write buffer
`timescale 1ns/1ps
module swb_mem_model (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        memCmdValid,
    input  wire logic        memCmdWrite,
    input  wire logic [25:0] memCmdAddr,
    input  wire logic [31:0] memCmdData,
    input  wire logic [3:0]  memCmdBe,
    input  wire logic        svcReq,
    input  wire logic        grantOff,
    input  wire logic [1:0]  lat,
    output logic             memCmdDone,
    output logic      [31:0] memRdData,
    output logic             svcGrant,
    output logic             refreshReq
);
    logic [31:0] mem [logic [25:0]];
    logic [25:0] order [$];
    logic [31:0] cur;
    logic [1:0]  waitN;
    logic [5:0]  tick;

    always @(posedge clk_sys or negedge resetn)
        if (!resetn)
        begin
            {memCmdDone, svcGrant, refreshReq, waitN, tick} <= '0;
            memRdData <= 32'h0;
        end
        else
        begin
            tick <= tick + 6'h01;
            refreshReq <= tick > 6'h3b;
            svcGrant <= svcReq && !grantOff && !refreshReq;
            memCmdDone <= 1'b0;
            memRdData <= ~memRdData;
            if (memCmdValid && !memCmdDone)
            begin
                if (waitN < lat)
                    waitN <= waitN + 2'h1;
                else
                begin
                    waitN <= 2'h0;
                    memCmdDone <= 1'b1;
                    cur = mem.exists(memCmdAddr) ? mem[memCmdAddr] :
                        {memCmdAddr[15:0], ~memCmdAddr[15:0]};
                    if (memCmdWrite)
                    begin
                        for (int b = 0; b < 4; b++)
                            if (memCmdBe[b])
                                cur[8*b+:8] = memCmdData[8*b+:8];
                        mem[memCmdAddr] = cur;
                        order.push_back(memCmdAddr);
                    end
                    else
                        memRdData <= cur;
                end
            end
        end
endmodule

// >>> tb/swb_properties.sv
// assertion checker bound to the write buffer top
`timescale 1ns/1ps
module swb_properties #(
    parameter int DEPTH = 32
) (
    input wire logic        clk_sys,
    input wire logic        resetn,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [11:0] regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic [7:0]  regRdData,
    input wire logic        mstWrReq,
    input wire logic        mstWrReady,
    input wire logic [25:0] mstWrAddr,
    input wire logic        mstRdReq,
    input wire logic        mstRdAck,
    input wire logic [31:0] mstRdData,
    input wire logic        memCmdValid,
    input wire logic        memCmdWrite,
    input wire logic [25:0] memCmdAddr,
    input wire logic [3:0]  memCmdBe,
    input wire logic        memCmdDone,
    input wire logic        svcReq,
    input wire logic        svcGrant,
    input wire logic        refreshReq
);
    logic enShadow;

    // enable bit as last written
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn)
            enShadow <= 1'b0;
        else if (regWrEn && regAddr == swb_pkg::CTL_OFFSET)
            enShadow <= regWrData[swb_pkg::CTL_ENABLE_BIT];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_rd_done;
        memCmdValid && !memCmdWrite && memCmdDone;
    endsequence
    sequence s_direct_take;
        !enShadow && !$past(enShadow) && mstWrReq && mstWrReady;
    endsequence
    sequence s_parked_idle;
        (svcReq && svcGrant && !memCmdValid && !mstRdReq) ##1
        (svcReq && svcGrant && !memCmdValid && !mstRdReq && !refreshReq);
    endsequence

    a_rd_ack_done: assert property (s_rd_done |=> mstRdAck)
        else $error("read ack missing after sdram done");
    a_rd_ack_cause: assert property ($rose(mstRdAck) |->
        $past(memCmdValid && !memCmdWrite && memCmdDone))
        else $error("read ack without sdram read");
    a_rd_ack_pulse: assert property (mstRdAck |=> !mstRdAck)
        else $error("read ack longer than one cycle");
    a_rd_data_hold: assert property (!mstRdAck |-> $stable(mstRdData))
        else $error("read data moved without ack");
    a_cmd_held: assert property (memCmdValid && !memCmdDone |=>
        memCmdValid && $stable(memCmdAddr) && $stable(memCmdWrite))
        else $error("sdram command dropped or changed");
    a_rd_be_full: assert property (memCmdValid && !memCmdWrite |->
        memCmdBe == 4'hf)
        else $error("sdram read without all byte enables");
    a_svc_from_alloc: assert property ($rose(svcReq) |->
        $past(mstWrReq && mstWrReady))
        else $error("service request without a taken write");
    a_direct_write: assert property (s_direct_take |=> memCmdValid &&
        memCmdWrite && memCmdAddr == $past(mstWrAddr))
        else $error("disabled write not sent straight to sdram");
    a_park_drain: assert property (s_parked_idle |-> ##[1:2]
        (memCmdValid && memCmdWrite))
        else $error("granted buffer did not drain");
    a_reserved_zero: assert property (regRdData[7:5] == 3'h0)
        else $error("reserved control bits read set");
    a_unmapped_zero: assert property (regRdEn &&
        regAddr != swb_pkg::CTL_OFFSET |=> regRdData == 8'h00)
        else $error("unmapped register read not zero");
endmodule

bind swb_top swb_properties #(.DEPTH(DEPTH)) chk_i (.*);

// >>> tb/test_sdram_snooping_write_buffer.sv
// self-checking bench of the snooping write buffer
`timescale 1ns/1ps
module test_sdram_snooping_write_buffer;
    logic        clk_sys, resetn, regWrEn, regRdEn, readAheadEnable;
    logic [11:0] regAddr;
    logic [7:0]  regWrData, regRdData, v;
    logic        mstWrReq, mstWrReady, mstRdReq, mstRdAck;
    logic [25:0] mstWrAddr, mstRdAddr, memCmdAddr, a;
    logic [31:0] mstWrData, mstRdData, memCmdData, memRdData, d, seed;
    logic [3:0]  mstWrBe, memCmdBe;
    logic        memCmdValid, memCmdWrite, memCmdDone;
    logic        svcReq, svcGrant, refreshReq, grantOff;
    logic [1:0]  lat;
    logic [31:0] refMem [logic [25:0]];
    logic [25:0] expOrder [$];
    int          error_cnt, total_checks, sumw, i, j, lvl;

    swb_top #(.DEPTH(32)) uut (.*);
    swb_mem_model pm (.*);

    initial
    begin
        clk_sys = 0;
        forever #4 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] expect_rd(input logic [25:0] ea);
        return refMem.exists(ea) ? refMem[ea] : {ea[15:0], ~ea[15:0]};
    endfunction

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tmo(input string nm);
        error_cnt++;
        $display("BAD %s expected handshake got timeout", nm);
        give_verdict();
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h got %h", nm, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] wd,
                          input logic [11:0] ra = swb_pkg::CTL_OFFSET);
        regWrEn = 1;
        regAddr = ra;
        regWrData = wd;
        @(negedge clk_sys);
        regWrEn = 0;
        @(negedge clk_sys);
    endtask

    task automatic reg_rd(output logic [7:0] rd,
                          input logic [11:0] ra = swb_pkg::CTL_OFFSET);
        regRdEn = 1;
        regAddr = ra;
        @(negedge clk_sys);
        regRdEn = 0;
        @(negedge clk_sys);
        rd = regRdData;
    endtask

    task automatic m_wr(input logic [25:0] wa, input logic [31:0] wd,
                        input logic [3:0] wb);
        logic r;
        int   n;
        mstWrReq = 1;
        mstWrAddr = wa;
        mstWrData = wd;
        mstWrBe = wb;
        n = 0;
        do
        begin
            r = mstWrReady;
            @(negedge clk_sys);
            n++;
        end while (r !== 1'b1 && n < 500);
        if (r !== 1'b1)
            tmo("write take");
        sumw += n - 1;
        if (!refMem.exists(wa))
            refMem[wa] = expect_rd(wa);
        for (int b = 0; b < 4; b++)
            if (wb[b])
                refMem[wa][8*b+:8] = wd[8*b+:8];
    endtask

    task automatic m_rd(input logic [25:0] ra, output logic [31:0] rd);
        int n;
        mstRdReq = 1;
        mstRdAddr = ra;
        n = 0;
        do
        begin
            @(negedge clk_sys);
            n++;
        end while (mstRdAck !== 1'b1 && n < 500);
        if (mstRdAck !== 1'b1)
            tmo("read ack");
        rd = mstRdData;
        mstRdReq = 0;
        @(negedge clk_sys);
    endtask

    task automatic drain(input logic [7:0] ctl);
        int n;
        reg_wr(ctl | 8'h10);
        reg_rd(v);
        chk("flush busy", ctl | 8'h10, v);
        n = 0;
        do
        begin
            reg_rd(v);
            n++;
        end while (v[4] !== 1'b0 && n < 300);
        if (v[4] !== 1'b0)
            tmo("flush");
        chk("flush done", ctl, v);
    endtask

    task automatic chk_mem();
        foreach (refMem[x])
            chk("sdram word", refMem[x], pm.mem[x]);
    endtask

    initial
    begin
        {resetn, regWrEn, regRdEn, mstWrReq, mstRdReq, grantOff} = '0;
        {regAddr, regWrData, mstWrAddr, mstWrData, mstWrBe} = '0;
        {mstRdAddr, lat, sumw} = '0;
        seed = 30;
        repeat (5) @(negedge clk_sys);
        resetn = 1;
        @(negedge clk_sys);
        reg_rd(v);
        chk("ctl reset", 0, v);
        chk("ready reset", 1, mstWrReady);
        reg_wr(8'h1f, 12'h044);
        reg_rd(v, 12'h044);
        chk("unmapped read", 0, v);
        reg_rd(v);
        chk("ctl kept", 0, v);
        for (i = 0; i < 4; i++)
        begin
            reg_wr(8'(4 * i + 2));
            reg_rd(v);
            chk("ctl fields", 4 * i + 2, v);
            chk("read ahead", 1, readAheadEnable);
        end
        m_wr(26'h77, rnd(), 4'h6);
        mstWrReq = 0;
        m_rd(26'h77, d);
        chk("direct read", expect_rd(26'h77), d);
        chk_mem();
        $display("register and direct test done");
        grantOff = 1;
        sumw = 0;
        pm.order.delete();
        for (i = 0; i < 4; i++)
        begin
            lvl = (i == 3) ? 28 : 8 * i + 8;
            reg_wr(8'(4 * i + 1));
            for (j = 0; j < 3 * lvl; j++)
                m_wr(26'h100 + 26'(j % lvl), rnd(), 4'(j / lvl + 1));
            chk("svc quiet", 0, svcReq);
            m_wr(26'h3ff, rnd(), 4'hf);
            chk("svc raised", 1, svcReq);
            mstWrReq = 0;
            for (j = 0; j < lvl; j++)
                expOrder.push_back(26'h100 + 26'(j));
            expOrder.push_back(26'h3ff);
            drain(8'(4 * i + 1));
        end
        chk("drain count", expOrder.size(), pm.order.size());
        foreach (expOrder[x])
            chk("drain order", expOrder[x], pm.order[x]);
        reg_wr(8'h0d);
        chk("read ahead off", 0, readAheadEnable);
        for (i = 0; i < 32; i++)
            m_wr(26'h200 + 26'(i), rnd(), 4'hf);
        chk("zero wait", 0, sumw);
        chk("full refuse", 0, mstWrReady);
        mstWrReq = 0;
        m_rd(26'h205, d);
        chk("full hit read", expect_rd(26'h205), d);
        drain(8'h0d);
        chk_mem();
        $display("threshold and full test done");
        grantOff = 0;
        reg_wr(8'h05);
        for (i = 0; i < 400; i++)
        begin
            lat = 2'(rnd());
            a = 26'h40 + 26'(rnd() % 24);
            if (rnd() % 3 != 0)
                m_wr(a, rnd(), 4'(rnd() % 15 + 1));
            else
            begin
                mstWrReq = 0;
                m_rd(a, d);
                chk("read merge", expect_rd(a), d);
            end
        end
        mstWrReq = 0;
        reg_wr(8'h04);
        m_rd(a, d);
        chk("read in drain", expect_rd(a), d);
        m_wr(a + 26'h1, rnd(), 4'h9);
        mstWrReq = 0;
        m_rd(a + 26'h1, d);
        chk("direct again", expect_rd(a + 26'h1), d);
        chk_mem();
        $display("random and disable test done");
        give_verdict();
    end
endmodule
